// file: core/reset_stop_watchdog.sv
`timescale 1ns/1ns
`default_nettype none

module reset_stop_watchdog (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // option bits
  input wire rsw_pkg::option_t i_options,
  // pins and analog sources
  input wire logic i_reset_pin_n,
  input wire logic i_brownout,
  input wire logic i_debug_pin,
  input wire logic i_wdt_rc_osc,
  input wire logic [rsw_pkg::GPIO_W-1:0] i_gpio,
  input wire logic [rsw_pkg::GPIO_W-1:0] i_gpio_wake_en,
  // cpu side
  input wire logic i_stop_instr,
  input wire logic i_refresh_instr,
  input wire logic i_debug_reset_bit,
  input wire logic [7:0] i_reload_upper_byte,
  input wire logic [7:0] i_reload_high_byte,
  input wire logic [7:0] i_reload_low_byte,
  // reset controller
  output logic o_system_reset,
  output logic o_stop_recovery,
  // power control
  output logic o_stop_mode,
  output logic o_sys_clock_enable,
  output logic o_cpu_halt,
  output logic o_pc_hold,
  output logic o_osc_enable,
  output logic o_periph_idle,
  output logic o_brownout_enable,
  output logic o_crystal_input_pin_out,
  output logic o_crystal_input_pin_oe,
  output logic o_crystal_output_pin_out,
  output logic o_crystal_output_pin_oe,
  // watchdog
  output logic o_wdt_osc_enable,
  output logic o_wdt_running,
  output logic o_wdt_irq,
  output logic [rsw_pkg::COUNT_W-1:0] o_wdt_count
);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [1:0] rst_pin_sync;
  logic [1:0] brown_sync;
  logic [1:0] dbg_sync;
  logic [1:0] osc_sync;
  logic osc_prev;
  logic [rsw_pkg::GPIO_W-1:0] gpio_s1;
  logic [rsw_pkg::GPIO_W-1:0] gpio_s2;
  logic [rsw_pkg::GPIO_W-1:0] gpio_s3;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rst_pin_sync <= 2'h3;
      brown_sync <= 2'h0;
      dbg_sync <= 2'h3;
      osc_sync <= 2'h0;
      osc_prev <= 1'b0;
      gpio_s1 <= '0;
      gpio_s2 <= '0;
      gpio_s3 <= '0;
    end else begin
      rst_pin_sync <= {rst_pin_sync[0], i_reset_pin_n};
      brown_sync <= {brown_sync[0], i_brownout};
      dbg_sync <= {dbg_sync[0], i_debug_pin};
      osc_sync <= {osc_sync[0], i_wdt_rc_osc};
      osc_prev <= osc_sync[1];
      gpio_s1 <= i_gpio;
      gpio_s2 <= gpio_s1;
      gpio_s3 <= gpio_s2;
    end
  end

  // ----------------------------------------
  // event decode
  // ----------------------------------------
  rsw_pkg::power_state_t state;
  rsw_pkg::power_state_t next_state;
  logic [rsw_pkg::HOLD_W-1:0] hold;
  logic [rsw_pkg::HOLD_W-1:0] next_hold;
  logic wdt_on;
  logic next_wdt_on;
  logic [rsw_pkg::COUNT_W-1:0] count;
  logic [rsw_pkg::COUNT_W-1:0] next_count;
  logic next_irq;
  logic [rsw_pkg::COUNT_W-1:0] reload;
  logic stop_now;
  logic tick;
  logic counting;
  logic timeout;
  logic refresh_ok;
  logic wake;
  logic sys_cause;

  assign reload = {i_reload_upper_byte, i_reload_high_byte, i_reload_low_byte};
  assign stop_now = (state == rsw_pkg::PM_STOP);
  // rising edge of the rc clock is the only time base of the counter
  assign tick = osc_sync[1] & ~osc_prev;
  // frozen in stop unless configured to keep running
  assign counting = wdt_on && (state != rsw_pkg::PM_RESET)
    && (!stop_now || i_options.watchdog_run_in_stop);
  assign timeout = counting && tick && (count == rsw_pkg::COUNT_RESET);
  // near the end a refresh can no longer save the device
  assign refresh_ok = i_refresh_instr && (state == rsw_pkg::PM_RUN)
    && (!wdt_on || count > rsw_pkg::REFRESH_LIMIT);
  assign wake = stop_now && (timeout || !dbg_sync[1]
    || |((gpio_s2 ^ gpio_s3) & i_gpio_wake_en));
  // brownout is only heard while its detector is powered
  assign sys_cause = (brown_sync[1] && (!stop_now || i_options.brownout_always_on))
    || !rst_pin_sync[1] || i_debug_reset_bit
    || (timeout && !stop_now && i_options.timeout_response_select);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_hold = hold;
    next_wdt_on = wdt_on;
    next_count = count;
    next_irq = timeout && !stop_now && !i_options.timeout_response_select;
    if (hold != rsw_pkg::HOLD_RESET) begin
      next_hold = hold - 4'h1;
    end
    if (refresh_ok) begin
      next_wdt_on = 1'b1;
      next_count = reload;
    end else if (counting && tick) begin
      if (count == rsw_pkg::COUNT_RESET) begin
        next_count = reload;
      end else begin
        next_count = count - 24'h1;
      end
    end
    case (state)
      rsw_pkg::PM_RESET: begin
        next_wdt_on = 1'b0;
        if (hold <= 4'h1) begin
          next_state = rsw_pkg::PM_RUN;
          next_wdt_on = !i_options.watchdog_always_on;
          next_count = reload;
        end
      end
      rsw_pkg::PM_RUN: begin
        if (i_stop_instr) begin
          next_state = rsw_pkg::PM_STOP;
        end
      end
      rsw_pkg::PM_STOP: begin
        if (wake) begin
          next_state = rsw_pkg::PM_RECOVER;
          next_hold = rsw_pkg::RESET_PULSE_CYCLES;
          if (i_options.watchdog_always_on) begin
            next_wdt_on = 1'b0;
          end
        end
      end
      rsw_pkg::PM_RECOVER: begin
        if (hold <= 4'h1) begin
          next_state = rsw_pkg::PM_RUN;
        end
      end
      default: begin
        next_state = rsw_pkg::PM_RESET;
      end
    endcase
    // a system reset outranks every other event
    if (sys_cause) begin
      next_state = rsw_pkg::PM_RESET;
      next_hold = rsw_pkg::RESET_PULSE_CYCLES;
      next_wdt_on = 1'b0;
      next_irq = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state <= rsw_pkg::PM_RESET;
      hold <= rsw_pkg::RESET_PULSE_CYCLES;
      wdt_on <= 1'b0;
      count <= rsw_pkg::COUNT_RESET;
      o_system_reset <= 1'b1;
      o_stop_recovery <= 1'b0;
      o_stop_mode <= 1'b0;
      o_sys_clock_enable <= 1'b1;
      o_cpu_halt <= 1'b0;
      o_pc_hold <= 1'b0;
      o_osc_enable <= 1'b1;
      o_periph_idle <= 1'b0;
      o_brownout_enable <= 1'b1;
      o_crystal_input_pin_out <= 1'b0;
      o_crystal_input_pin_oe <= 1'b0;
      o_crystal_output_pin_out <= 1'b0;
      o_crystal_output_pin_oe <= 1'b0;
      o_wdt_osc_enable <= 1'b0;
      o_wdt_running <= 1'b0;
      o_wdt_irq <= 1'b0;
      o_wdt_count <= rsw_pkg::COUNT_RESET;
    end else begin
      state <= next_state;
      hold <= next_hold;
      wdt_on <= next_wdt_on;
      count <= next_count;
      o_system_reset <= (next_state == rsw_pkg::PM_RESET);
      o_stop_recovery <= (next_state == rsw_pkg::PM_RECOVER);
      o_stop_mode <= (next_state == rsw_pkg::PM_STOP);
      o_sys_clock_enable <= (next_state != rsw_pkg::PM_STOP);
      o_cpu_halt <= (next_state == rsw_pkg::PM_STOP);
      o_pc_hold <= (next_state == rsw_pkg::PM_STOP);
      o_osc_enable <= (next_state != rsw_pkg::PM_STOP);
      o_periph_idle <= (next_state == rsw_pkg::PM_STOP);
      o_brownout_enable <= (next_state != rsw_pkg::PM_STOP)
        || i_options.brownout_always_on;
      o_crystal_input_pin_out <= (next_state == rsw_pkg::PM_STOP);
      o_crystal_input_pin_oe <= (next_state == rsw_pkg::PM_STOP);
      o_crystal_output_pin_out <= 1'b0;
      o_crystal_output_pin_oe <= (next_state == rsw_pkg::PM_STOP);
      o_wdt_osc_enable <= next_wdt_on && ((next_state != rsw_pkg::PM_STOP)
        || i_options.watchdog_run_in_stop);
      o_wdt_running <= next_wdt_on;
      o_wdt_irq <= next_irq;
      o_wdt_count <= next_count;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_pin_reset;
    @(posedge i_core_clk) disable iff (i_reset)
    !rst_pin_sync[1] |=> o_system_reset [*2];
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset missed");

  property p_debug_wake;
    @(posedge i_core_clk) disable iff (i_reset)
    stop_now && !dbg_sync[1] && !sys_cause |=> o_stop_recovery && !o_stop_mode;
  endproperty
  a_debug_wake: assert property (p_debug_wake) else $error("debug wake missed");

  property p_one_type;
    @(posedge i_core_clk) disable iff (i_reset)
    !(o_system_reset && o_stop_recovery);
  endproperty
  a_one_type: assert property (p_one_type) else $error("two reset types");

  property p_enter_stop;
    @(posedge i_core_clk) disable iff (i_reset)
    state == rsw_pkg::PM_RUN && i_stop_instr && !sys_cause |=> o_stop_mode;
  endproperty
  a_enter_stop: assert property (p_enter_stop) else $error("stop not entered");

  property p_stop_pins;
    @(posedge i_core_clk) disable iff (i_reset)
    o_stop_mode |-> o_crystal_input_pin_out && o_crystal_input_pin_oe
      && !o_crystal_output_pin_out && o_crystal_output_pin_oe && !o_osc_enable
      && !o_sys_clock_enable && o_cpu_halt && o_pc_hold;
  endproperty
  a_stop_pins: assert property (p_stop_pins) else $error("stop outputs wrong");

  property p_frozen;
    @(posedge i_core_clk) disable iff (i_reset)
    stop_now && !i_options.watchdog_run_in_stop && !sys_cause |=> $stable(o_wdt_count);
  endproperty
  a_frozen: assert property (p_frozen) else $error("counter ran in stop");

  property p_brown_stop;
    @(posedge i_core_clk) disable iff (i_reset)
    o_stop_mode |-> o_brownout_enable == $past(i_options.brownout_always_on);
  endproperty
  a_brown_stop: assert property (p_brown_stop) else $error("brownout enable wrong");

  property p_leave_stop;
    @(posedge i_core_clk) disable iff (i_reset)
    o_stop_mode ##1 !o_stop_mode |-> o_stop_recovery || o_system_reset;
  endproperty
  a_leave_stop: assert property (p_leave_stop) else $error("stop left directly");

  property p_late_refresh;
    @(posedge i_core_clk) disable iff (i_reset)
    i_refresh_instr && wdt_on && count <= rsw_pkg::REFRESH_LIMIT
      && count != rsw_pkg::COUNT_RESET && !sys_cause |=> o_wdt_count <= rsw_pkg::REFRESH_LIMIT;
  endproperty
  a_late_refresh: assert property (p_late_refresh) else $error("late refresh taken");

  property p_refresh;
    @(posedge i_core_clk) disable iff (i_reset)
    refresh_ok && !sys_cause |=> o_wdt_count == $past(reload) && o_wdt_running;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh not loaded");

  property p_irq;
    @(posedge i_core_clk) disable iff (i_reset)
    timeout && !stop_now && !i_options.timeout_response_select && !sys_cause
      |=> o_wdt_irq && !o_system_reset ##1 !o_wdt_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt response wrong");

endmodule : reset_stop_watchdog

`default_nettype wire

// file: core/rsw_pkg.sv
`default_nettype none

package rsw_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int COUNT_W = 24;
  localparam int GPIO_W = 8;
  localparam int HOLD_W = 4;

  // ----------------------------------------
  // watchdog counter values
  // ----------------------------------------
  localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;
  localparam logic [COUNT_W-1:0] REFRESH_LIMIT = 24'h000002;
  localparam logic [COUNT_W-1:0] MIN_RELOAD = 24'h000004;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  // one rc tick per 100 us, so period in ms is (reload + 1) / 10
  localparam int RC_OSC_FREQ_KHZ = 10;
  localparam int CORE_CLK_KHZ = 25000;
  localparam int RESET_PULSE_NS = 400;
  localparam logic [HOLD_W-1:0] RESET_PULSE_CYCLES =
    HOLD_W'((RESET_PULSE_NS * CORE_CLK_KHZ + 999999) / 1000000);
  localparam logic [HOLD_W-1:0] HOLD_RESET = 4'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic timeout_response_select;
    logic watchdog_always_on;
    logic brownout_always_on;
    logic watchdog_run_in_stop;
  } option_t;

  typedef enum logic [1:0] {PM_RESET, PM_RUN, PM_STOP, PM_RECOVER} power_state_t;

endpackage : rsw_pkg

`default_nettype wire

// file: test/test_reset_stop_watchdog.sv
`timescale 1ns/1ns
`default_nettype none
module test_reset_stop_watchdog;
  logic core_clk, reset, reset_pin_n, brownout, debug_pin, rc_osc;
  logic stop_instr, refresh_instr, debug_reset_bit;
  rsw_pkg::option_t opts;
  logic [7:0] gpio, wake_en, rl_u, rl_h, rl_l;
  logic system_reset, stop_recovery, stop_mode, clk_en, cpu_halt, pc_hold, osc_en;
  logic periph_idle, bo_en, xin_out, xin_oe, crystal_output_pin_out, crystal_output_pin_oe, wdt_osc_en, running, irq;
  logic [rsw_pkg::COUNT_W-1:0] count;
  int failures = 0;
  int total_checks = 0;
  int irq_seen = 0;

  reset_stop_watchdog reset_stop_watchdog_inst (
    .i_core_clk(core_clk), .i_reset(reset), .i_options(opts), .i_reset_pin_n(reset_pin_n),
    .i_brownout(brownout), .i_debug_pin(debug_pin), .i_wdt_rc_osc(rc_osc), .i_gpio(gpio),
    .i_gpio_wake_en(wake_en), .i_stop_instr(stop_instr), .i_refresh_instr(refresh_instr),
    .i_debug_reset_bit(debug_reset_bit), .i_reload_upper_byte(rl_u),
    .i_reload_high_byte(rl_h), .i_reload_low_byte(rl_l), .o_system_reset(system_reset),
    .o_stop_recovery(stop_recovery), .o_stop_mode(stop_mode), .o_sys_clock_enable(clk_en),
    .o_cpu_halt(cpu_halt), .o_pc_hold(pc_hold), .o_osc_enable(osc_en),
    .o_periph_idle(periph_idle), .o_brownout_enable(bo_en),
    .o_crystal_input_pin_out(xin_out), .o_crystal_input_pin_oe(xin_oe),
    .o_crystal_output_pin_out(crystal_output_pin_out), .o_crystal_output_pin_oe(crystal_output_pin_oe),
    .o_wdt_osc_enable(wdt_osc_en), .o_wdt_running(running), .o_wdt_irq(irq),
    .o_wdt_count(count));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) if (irq === 1'b1) irq_seen++;

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : cyc

  task chk_bit(input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected bit at %0t: exp %h got %h", $time, exp, got);
    end
  endtask : chk_bit

  task chk_cnt(input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected count at %0t: exp %h got %h", $time, exp, got);
    end
  endtask : chk_cnt

  // bounded wait on reset (sel 0) or recovery (sel 1), then judge the level
  task wait_sig(input int sel, input logic val);
    int n;
    n = 0;
    while (n < 40 && (sel == 0 ? system_reset : stop_recovery) !== val) begin
      cyc(1);
      n++;
    end
    chk_bit(val, sel == 0 ? system_reset : stop_recovery);
  endtask : wait_sig

  // the rc clock only matters at its rising edge; long phases clear the synchroniser
  task rc_tick(input int n);
    repeat (n) begin
      rc_osc = 1'b1;
      cyc(5);
      rc_osc = 1'b0;
      cyc(5);
    end
  endtask : rc_tick

  // one-cycle instruction pulse, result looked at one edge after it is taken
  task pulse(input logic is_stop);
    if (is_stop) stop_instr = 1'b1;
    else refresh_instr = 1'b1;
    cyc(1);
    stop_instr = 1'b0;
    refresh_instr = 1'b0;
    cyc(1);
  endtask : pulse

  task do_reset(input logic ao);
    opts.watchdog_always_on = ao;
    reset = 1'b1;
    cyc(16);
    reset = 1'b0;
    cyc(1);
    chk_bit(1'b1, system_reset);
    wait_sig(0, 1'b0);
    chk_bit(~ao, running);
  endtask : do_reset

  task debug_wake;
    debug_pin = 1'b0;
    wait_sig(1, 1'b1);
    chk_bit(1'b0, stop_mode);
    debug_pin = 1'b1;
    wait_sig(1, 1'b0);
    chk_bit(1'b0, system_reset);
    chk_bit(1'b1, clk_en & osc_en & bo_en);
  endtask : debug_wake

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_count;
    do_reset(1'b0);
    chk_cnt(24'h000010, count);
    {rl_u, rl_h, rl_l} = 24'h010203;
    pulse(1'b0);
    chk_cnt(24'h010203, count);
    rc_tick(3);
    chk_cnt(24'h010200, count);
    pulse(1'b0);
    chk_cnt(24'h010203, count);
  endtask : t_count

  task t_timeout;
    opts.timeout_response_select = 1'b0;
    {rl_u, rl_h, rl_l} = 24'h000004;
    pulse(1'b0);
    rc_tick(2);
    pulse(1'b0);
    chk_cnt(24'h000002, count);
    rc_tick(2);
    irq_seen = 0;
    rc_tick(1);
    chk_bit(1'b1, irq_seen == 1);
    chk_cnt(24'h000004, count);
    chk_bit(1'b0, system_reset);
    opts.timeout_response_select = 1'b1;
    rc_tick(4);
    rc_osc = 1'b1;
    wait_sig(0, 1'b1);
    rc_osc = 1'b0;
    wait_sig(0, 1'b0);
  endtask : t_timeout

  task t_stop;
    opts.brownout_always_on = 1'b0;
    pulse(1'b1);
    chk_bit(1'b1, stop_mode);
    chk_bit(1'b0, osc_en);
    chk_bit(1'b1, xin_out & xin_oe & crystal_output_pin_oe);
    chk_bit(1'b0, crystal_output_pin_out);
    chk_bit(1'b0, clk_en);
    chk_bit(1'b1, cpu_halt & pc_hold);
    chk_bit(1'b1, periph_idle);
    chk_bit(1'b0, bo_en);
    chk_bit(1'b0, wdt_osc_en);
    // rc edges while stopped with the watchdog powered down must not count
    rc_tick(1);
    chk_cnt(24'h000004, count);
    debug_wake();
    opts.brownout_always_on = 1'b1;
    opts.watchdog_run_in_stop = 1'b1;
    pulse(1'b1);
    chk_bit(1'b1, bo_en);
    chk_bit(1'b1, wdt_osc_en);
    wake_en = 8'h08;
    gpio[3] = 1'b1;
    wait_sig(1, 1'b1);
    wait_sig(1, 1'b0);
    pulse(1'b0);
    pulse(1'b1);
    rc_tick(4);
    rc_osc = 1'b1;
    wait_sig(1, 1'b1);
    chk_bit(1'b0, system_reset);
    rc_osc = 1'b0;
    wait_sig(1, 1'b0);
  endtask : t_stop

  task t_always_on;
    do_reset(1'b1);
    pulse(1'b0);
    chk_bit(1'b1, running);
    pulse(1'b1);
    debug_wake();
    chk_bit(1'b0, running);
  endtask : t_always_on

  task t_causes;
    for (int k = 0; k < 3; k++) begin
      case (k)
        0: reset_pin_n = 1'b0;
        1: brownout = 1'b1;
        default: debug_reset_bit = 1'b1;
      endcase
      cyc(3);
      reset_pin_n = 1'b1;
      brownout = 1'b0;
      debug_reset_bit = 1'b0;
      wait_sig(0, 1'b1);
      wait_sig(0, 1'b0);
    end
  endtask : t_causes

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    opts = '{timeout_response_select: 1'b1, watchdog_always_on: 1'b0,
             brownout_always_on: 1'b1, watchdog_run_in_stop: 1'b0};
    {reset_pin_n, brownout, debug_pin, rc_osc} = 4'ha;
    {stop_instr, refresh_instr, debug_reset_bit} = 3'h0;
    {gpio, wake_en} = 16'h0000;
    {rl_u, rl_h, rl_l} = 24'h000010;
    t_count();
    t_timeout();
    t_stop();
    t_always_on();
    t_causes();
    test_done();
  end

  // the whole run needs well under 2000 cycles
  initial begin
    repeat (8000) @(posedge core_clk);
    failures++;
    test_done();
  end
endmodule : test_reset_stop_watchdog
`default_nettype wire
